/* verilog/line_regs_params.svh */
// Register indices, field positions and reset values for the line-side register bank
`ifndef LINE_REGS_PARAMS_SVH
`define LINE_REGS_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_REVISION 8'h0D
`define IDX_RSVD_ZERO 8'h0E
`define IDX_GAIN_CTRL 8'h0F
`define IDX_INTL_CTRL 8'h10

// Revision register fields
`define REV_ONE_BIT 6
`define REV_CODE_HI 5
`define REV_CODE_LO 2

// Gain control fields
`define GAIN_TX_MUTE 7
`define GAIN_TX_ATT_HI 6
`define GAIN_TX_ATT_LO 4
`define GAIN_RX_MUTE 3
`define GAIN_RX_GAIN_HI 2
`define GAIN_RX_GAIN_LO 0

// International control fields
`define INTL_TERM_HIGH 7
`define INTL_HOOK_SEL 6
`define INTL_TERM_LOW 5
`define INTL_IIR 4
`define INTL_RINGER 1
`define INTL_RING_THR 0

// Writable bit masks and reset values
`define GAIN_WR_MASK 8'hFF
`define INTL_WR_MASK 8'hF3
`define GAIN_RESET 8'h00
`define INTL_RESET 8'h00
`define RSVD_READ 8'h00

// Spark quench codes that go with the slow and the 3 ms on-hook speeds
`define QUENCH_SLOW 2'h3
`define QUENCH_NONE 2'h0

`endif

/* verilog/line_regs_pkg.sv */
// Types and the level decode function shared by the line-side register bank
package line_regs_pkg;

  typedef enum logic [2:0] {
    LVL_0DB = 3'b000,
    LVL_3DB = 3'b001,
    LVL_6DB = 3'b010,
    LVL_9DB = 3'b011,
    LVL_12DB = 3'b100
  } level_e;

  typedef enum logic [1:0] {
    TERM_REAL_600 = 2'b00,
    TERM_GLOBAL_COMPLEX = 2'b01,
    TERM_TBR21_COMPLEX = 2'b10,
    TERM_NZ_COMPLEX = 2'b11
  } termination_e;

  typedef enum logic [1:0] {
    HOOK_UNDER_0P5MS = 2'b00,
    HOOK_3MS = 2'b01,
    HOOK_26MS = 2'b10
  } hook_speed_e;

  typedef struct packed {
    logic mute;
    level_e level;
  } path_s;

  typedef struct packed {
    termination_e term;
    hook_speed_e hook;
    logic iir_filter;
    logic ringer_synth;
    logic ring_thr_high;
  } line_cfg_s;

  // Codes 1xx all map to the top step
  function automatic level_e level_of(input logic [2:0] code);
    if (code[2]) begin
      return LVL_12DB;
    end
    return level_e'({1'b0, code[1:0]});
  endfunction

endpackage

/* verilog/path_decode.sv */
// Transmit and receive path decode of the gain control byte
`timescale 1ns/1ps
`include "line_regs_params.svh"

module path_decode
  import line_regs_pkg::*;
(
  // Register contents
  input wire logic [7:0] gain_ctrl,
  // Decoded paths
  output path_s tx_path,
  output path_s rx_path
);

  always_comb begin
    tx_path.mute = gain_ctrl[`GAIN_TX_MUTE];
    tx_path.level = level_of(gain_ctrl[`GAIN_TX_ATT_HI:`GAIN_TX_ATT_LO]);
    rx_path.mute = gain_ctrl[`GAIN_RX_MUTE];
    rx_path.level = level_of(gain_ctrl[`GAIN_RX_GAIN_HI:`GAIN_RX_GAIN_LO]);
  end

endmodule

/* verilog/intl_decode.sv */
// Line settings decode of the international control byte per device variant
`timescale 1ns/1ps
`include "line_regs_params.svh"

module intl_decode
  import line_regs_pkg::*;
#(
  parameter int TERM_COUNT = 4,
  parameter bit FAST_SYS_CLOCK = 1'b1
) (
  // Register contents and companion fields
  input wire logic [7:0] intl_ctrl,
  input wire logic on_hook_speed_second,
  input wire logic [1:0] spark_quench_field,
  // Decoded settings
  output line_cfg_s cfg
);

  localparam bit FULL = (TERM_COUNT == 4);

  logic term_hi;
  logic term_lo;
  logic hook_sel;

  assign term_hi = intl_ctrl[`INTL_TERM_HIGH];
  assign term_lo = intl_ctrl[`INTL_TERM_LOW];
  assign hook_sel = intl_ctrl[`INTL_HOOK_SEL];

  always_comb begin
    cfg.term = TERM_REAL_600;
    if (TERM_COUNT == 4) begin
      cfg.term = termination_e'({term_hi, term_lo});
    end else if (TERM_COUNT == 2 && (term_hi ^ term_lo)) begin
      cfg.term = TERM_TBR21_COMPLEX;
    end
    cfg.hook = HOOK_UNDER_0P5MS;
    if (FULL) begin
      if (hook_sel && spark_quench_field == `QUENCH_SLOW) begin
        cfg.hook = HOOK_26MS;
      end else if (!hook_sel && on_hook_speed_second &&
                   spark_quench_field == `QUENCH_NONE) begin
        cfg.hook = HOOK_3MS;
      end
    end
    cfg.iir_filter = intl_ctrl[`INTL_IIR] & FAST_SYS_CLOCK;
    cfg.ringer_synth = intl_ctrl[`INTL_RINGER] & FULL;
    cfg.ring_thr_high = intl_ctrl[`INTL_RING_THR] & FULL;
  end

endmodule

/* verilog/line_side_gain_termination_regs.sv */
// APB register bank for line-side revision, gain and international settings
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "line_regs_params.svh"

module line_side_gain_termination_regs
  import line_regs_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int TERM_COUNT = 4,
  parameter bit FAST_SYS_CLOCK = 1'b1,
  // Arbitrary revision value
  parameter logic [3:0] REVISION_CODE = 4'h1
) (
  // Clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Companion on-hook fields held in other registers
  input wire logic on_hook_speed_second,
  input wire logic [1:0] spark_quench_field,
  // Decoded settings
  output path_s tx_path,
  output path_s rx_path,
  output line_cfg_s line_cfg,
  // Raw field views
  output logic transmit_mute,
  output logic [2:0] transmit_attenuation,
  output logic receive_mute,
  output logic [2:0] receive_gain,
  output logic termination_select_high,
  output logic termination_select_low,
  output logic on_hook_speed_select,
  output logic recursive_filter_enable,
  output logic ringer_impedance_select,
  output logic ring_threshold_select
);

  generate
    if (TERM_COUNT != 1 && TERM_COUNT != 2 && TERM_COUNT != 4) begin : g_bad_terms
      $error("TERM_COUNT must be 1, 2 or 4");
    end
    if (ADDR_W < 7 || ADDR_W > 32) begin : g_bad_addr
      $error("ADDR_W must be 7 to 32");
    end
  endgenerate

  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_READ_ONLY = 2'b01,
    SEL_GAIN = 2'b10,
    SEL_INTL = 2'b11
  } target_e;

  logic [7:0] gain_r;
  logic [7:0] intl_r;
  logic [31:0] prdata_r;
  logic err_r;
  path_s tx_nxt;
  path_s rx_nxt;
  line_cfg_s cfg_nxt;
  logic [7:0] line_side_revision_code;
  logic mapped;
  logic setup;
  logic access;
  logic wr_ok;
  target_e target;

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    return ADDR_W'({idx, 2'b00});
  endfunction

  // Merge the low byte lane into a register under its writable mask
  function automatic logic [7:0] merge(
    input logic [7:0] old,
    input logic [7:0] wdata,
    input logic lane,
    input logic [7:0] mask
  );
    logic [7:0] upd;
    upd = (old & ~mask) | (wdata & mask);
    return lane ? upd : old;
  endfunction

  // Revision byte: fixed one, revision code, zeros elsewhere
  always_comb begin
    line_side_revision_code = 8'h00;
    line_side_revision_code[`REV_ONE_BIT] = 1'b1;
    line_side_revision_code[`REV_CODE_HI:`REV_CODE_LO] = REVISION_CODE;
  end

  // Address decode
  always_comb begin
    target = SEL_NONE;
    mapped = 1'b1;
    if (paddr == byte_addr(`IDX_REVISION) || paddr == byte_addr(`IDX_RSVD_ZERO)) begin
      target = SEL_READ_ONLY;
    end else if (paddr == byte_addr(`IDX_GAIN_CTRL)) begin
      target = SEL_GAIN;
    end else if (paddr == byte_addr(`IDX_INTL_CTRL)) begin
      target = SEL_INTL;
    end else begin
      mapped = 1'b0;
    end
  end

  // Read data for the addressed register
  function automatic logic [7:0] read_byte(input logic [ADDR_W-1:0] addr);
    logic [7:0] val;
    val = 8'h00;
    if (addr == byte_addr(`IDX_REVISION)) begin
      val = line_side_revision_code;
    end else if (addr == byte_addr(`IDX_RSVD_ZERO)) begin
      val = `RSVD_READ;
    end else if (addr == byte_addr(`IDX_GAIN_CTRL)) begin
      val = gain_r;
    end else if (addr == byte_addr(`IDX_INTL_CTRL)) begin
      val = intl_r & `INTL_WR_MASK;
    end
    return val;
  endfunction

  // Bus phases; no wait states while enabled
  assign setup = psel & ~penable & clk_en;
  assign access = psel & penable & clk_en;
  assign pready = access;
  assign pslverr = access & err_r;
  assign prdata = prdata_r;
  assign wr_ok = access & pwrite & mapped;

  // Read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0000_0000 : {24'h00_0000, read_byte(paddr)};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r <= 1'b0;
    end else if (setup) begin
      err_r <= ~mapped;
    end
  end

  // Gain control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_r <= `GAIN_RESET;
    end else if (wr_ok && target == SEL_GAIN) begin
      gain_r <= merge(gain_r, pwdata[7:0], pstrb[0], `GAIN_WR_MASK);
    end
  end

  // International control register; reserved bits never store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intl_r <= `INTL_RESET;
    end else if (wr_ok && target == SEL_INTL) begin
      intl_r <= merge(intl_r, pwdata[7:0], pstrb[0], `INTL_WR_MASK);
    end
  end

  path_decode u_path_decode (
    .gain_ctrl(gain_r),
    .tx_path(tx_nxt),
    .rx_path(rx_nxt)
  );

  intl_decode #(
    .TERM_COUNT(TERM_COUNT),
    .FAST_SYS_CLOCK(FAST_SYS_CLOCK)
  ) u_intl_decode (
    .intl_ctrl(intl_r),
    .on_hook_speed_second(on_hook_speed_second),
    .spark_quench_field(spark_quench_field),
    .cfg(cfg_nxt)
  );

  // Decoded path settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_path <= '{mute: 1'b0, level: LVL_0DB};
      rx_path <= '{mute: 1'b0, level: LVL_0DB};
    end else if (clk_en) begin
      tx_path <= tx_nxt;
      rx_path <= rx_nxt;
    end
  end

  // Decoded line settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_cfg <= '{term: TERM_REAL_600, hook: HOOK_UNDER_0P5MS, iir_filter: 1'b0,
                    ringer_synth: 1'b0, ring_thr_high: 1'b0};
    end else if (clk_en) begin
      line_cfg <= cfg_nxt;
    end
  end

  // Raw field views straight from the registers
  assign transmit_mute = gain_r[`GAIN_TX_MUTE];
  assign transmit_attenuation = gain_r[`GAIN_TX_ATT_HI:`GAIN_TX_ATT_LO];
  assign receive_mute = gain_r[`GAIN_RX_MUTE];
  assign receive_gain = gain_r[`GAIN_RX_GAIN_HI:`GAIN_RX_GAIN_LO];
  assign termination_select_high = intl_r[`INTL_TERM_HIGH];
  assign termination_select_low = intl_r[`INTL_TERM_LOW];
  assign on_hook_speed_select = intl_r[`INTL_HOOK_SEL];
  assign recursive_filter_enable = intl_r[`INTL_IIR];
  assign ringer_impedance_select = intl_r[`INTL_RINGER];
  assign ring_threshold_select = intl_r[`INTL_RING_THR];

endmodule

/* bench/line_regs_assertions.sv */
// Port-level checker for the line-side register bank
`timescale 1ns/1ps
module line_regs_checker
  import line_regs_pkg::*;
#(
  parameter logic [3:0] REVISION_CODE = 4'h1
) (
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Companion inputs and outputs
  input wire logic on_hook_speed_second,
  input wire logic [1:0] spark_quench_field,
  input path_s tx_path,
  input path_s rx_path,
  input line_cfg_s line_cfg,
  input wire logic transmit_mute,
  input wire logic [2:0] transmit_attenuation,
  input wire logic receive_mute,
  input wire logic [2:0] receive_gain,
  input wire logic termination_select_high,
  input wire logic termination_select_low,
  input wire logic on_hook_speed_select,
  input wire logic recursive_filter_enable,
  input wire logic ringer_impedance_select,
  input wire logic ring_threshold_select
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_acc;
  assign rd_acc = psel && penable && !pwrite;
  function automatic logic [2:0] lvl(input logic [2:0] c);
    return c[2] ? 3'h4 : {1'b0, c[1:0]};
  endfunction
  function automatic logic [1:0] hk(input logic s, input logic t, input logic [1:0] q);
    return (s && q == 2'h3) ? 2'h2 : ((!s && t && q == 2'h0) ? 2'h1 : 2'h0);
  endfunction
  AST_TX_PATH: assert property (clk_en |=> tx_path == {$past(transmit_mute),
    lvl($past(transmit_attenuation))}) else $error("tx path decode wrong");
  AST_RX_PATH: assert property (clk_en |=> rx_path == {$past(receive_mute),
    lvl($past(receive_gain))}) else $error("rx path decode wrong");
  AST_TERM: assert property (clk_en |=> line_cfg.term ==
    $past({termination_select_high, termination_select_low})) else $error("termination wrong");
  AST_HOOK: assert property (clk_en |=> line_cfg.hook == hk($past(on_hook_speed_select),
    $past(on_hook_speed_second), $past(spark_quench_field))) else $error("hook speed wrong");
  AST_LINE_BITS: assert property (clk_en |=> line_cfg[2:0] == $past({recursive_filter_enable,
    ringer_impedance_select, ring_threshold_select})) else $error("line bits wrong");
  AST_REV_READ: assert property (rd_acc && paddr == 8'h34 |->
    prdata == {25'h0, 1'b1, REVISION_CODE, 2'h0}) else $error("revision read wrong");
  AST_RSVD_READ: assert property (rd_acc && paddr == 8'h38 |-> prdata == 32'h0)
    else $error("reserved read not zero");
  AST_INTL_READ: assert property (rd_acc && paddr == 8'h40 |-> prdata[3:2] == 2'h0)
    else $error("intl reserved bits set");
  AST_READY_FROZEN: assert property (!clk_en |-> !pready)
    else $error("pready high while frozen");
endmodule
bind line_side_gain_termination_regs line_regs_checker #(.REVISION_CODE(REVISION_CODE)) chk (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .on_hook_speed_second(on_hook_speed_second),
  .spark_quench_field(spark_quench_field), .tx_path(tx_path), .rx_path(rx_path),
  .line_cfg(line_cfg), .transmit_mute(transmit_mute), .transmit_attenuation(transmit_attenuation),
  .receive_mute(receive_mute), .receive_gain(receive_gain),
  .termination_select_high(termination_select_high),
  .termination_select_low(termination_select_low), .on_hook_speed_select(on_hook_speed_select),
  .recursive_filter_enable(recursive_filter_enable),
  .ringer_impedance_select(ringer_impedance_select),
  .ring_threshold_select(ring_threshold_select));

/* bench/line_side_gain_termination_regs_test.sv */
// Self-checking bench for the line-side register bank
`timescale 1ns/1ps
module line_side_gain_termination_regs_test;
  import line_regs_pkg::*;
  localparam logic [3:0] REV = 4'hA;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hook_second, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] quench;
  logic en;
  logic [3:0] strb;
  path_s tx_path, rx_path;
  line_cfg_s line_cfg;
  int fail_count = 0;
  int checks_done = 0;
  line_side_gain_termination_regs #(.REVISION_CODE(REV)) dut (.pclk(pclk), .presetn(presetn),
    .clk_en(en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .on_hook_speed_second(hook_second), .spark_quench_field(quench), .tx_path(tx_path),
    .rx_path(rx_path), .line_cfg(line_cfg), .transmit_mute(), .transmit_attenuation(),
    .receive_mute(), .receive_gain(), .termination_select_high(), .termination_select_low(),
    .on_hook_speed_select(), .recursive_filter_enable(), .ringer_impedance_select(),
    .ring_threshold_select());
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      $display("MISMATCH pready expected 1 seen %b", pready);
      fail_count++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic settle;
    repeat (3) @(posedge pclk);
    #1;
  endtask
  function automatic logic [2:0] lvl(input logic [2:0] c);
    return c[2] ? LVL_12DB : {1'b0, c[1:0]};
  endfunction
  task automatic t_gain;
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      xfer(1'b1, 8'h3C, {24'h0, c[0], c, ~c[0], ~c});
      settle();
      chk("tx_path", {28'h0, c[0], lvl(c)}, 32'(tx_path));
      chk("rx_path", {28'h0, ~c[0], lvl(~c)}, 32'(rx_path));
    end
  endtask
  task automatic t_intl;
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      d = {i[1], 1'b0, i[0], i[0], 2'h3, i[1], ~i[1]};
      xfer(1'b1, 8'h40, {24'h0, d});
      settle();
      chk("term", {30'h0, i[1], i[0]}, 32'(line_cfg.term));
      chk("line_bits", {29'h0, i[0], i[1], ~i[1]}, 32'(line_cfg[2:0]));
      rdchk("intl", 8'h40, {24'h0, d & 8'hF3});
    end
  endtask
  task automatic t_hook;
    logic [1:0] e;
    for (int i = 0; i < 16; i++) begin
      @(posedge pclk);
      hook_second <= i[1];
      quench <= i[3:2];
      xfer(1'b1, 8'h40, {25'h0, i[0], 6'h0});
      settle();
      e = (i[0] && i[3:2] == 2'h3) ? HOOK_26MS : (!i[0] && i[3:1] == 3'h1) ? HOOK_3MS : 2'h0;
      chk("hook", {30'h0, e}, 32'(line_cfg.hook));
    end
  endtask
  task automatic t_protect;
    xfer(1'b1, 8'h3C, 32'h5A);
    xfer(1'b1, 8'h34, 32'hFF);
    chk("rev_wr_err", 32'h0, {31'h0, err});
    xfer(1'b1, 8'h38, 32'hFF);
    rdchk("revision", 8'h34, {25'h1, REV, 2'h0});
    rdchk("reserved", 8'h38, 32'h0);
    xfer(1'b1, 8'h44, 32'h12);
    chk("unmapped_err", 32'h1, {31'h0, err});
    strb <= 4'h0;
    xfer(1'b1, 8'h3C, 32'hFF);
    strb <= 4'hF;
    rdchk("gain", 8'h3C, 32'h5A);
  endtask
  task automatic t_freeze;
    @(posedge pclk);
    en <= 1'b0;
    quench <= 2'h0;
    psel <= 1'b1;
    pwrite <= 1'b1;
    paddr <= 8'h3C;
    pwdata <= 32'h3C;
    @(posedge pclk);
    penable <= 1'b1;
    settle();
    chk("frozen_ready", 32'h0, {31'h0, pready});
    chk("frozen_hook", {30'h0, HOOK_26MS}, 32'(line_cfg.hook));
    @(posedge pclk);
    en <= 1'b1;
    @(posedge pclk);
    chk("thawed_ready", 32'h1, {31'h0, pready});
    psel <= 1'b0;
    penable <= 1'b0;
    settle();
    chk("thawed_hook", {30'h0, HOOK_UNDER_0P5MS}, 32'(line_cfg.hook));
    rdchk("thawed_gain", 8'h3C, 32'h3C);
  endtask
  task automatic t_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    hook_second <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("gain_rst", 8'h3C, 32'h0);
    rdchk("intl_rst", 8'h40, 32'h0);
    rdchk("revision_rst", 8'h34, {25'h1, REV, 2'h0});
    chk("tx_rst", 32'h0, 32'(tx_path));
    chk("rx_rst", 32'h0, 32'(rx_path));
    chk("cfg_rst", 32'h0, 32'(line_cfg));
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    #200000;
    $display("MISMATCH watchdog expected finish seen timeout");
    fail_count++;
    end_of_test();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    hook_second = 1'b0;
    quench = 2'h0;
    en = 1'b1;
    strb = 4'hF;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("revision", 8'h34, {25'h1, REV, 2'h0});
    rdchk("reserved", 8'h38, 32'h0);
    t_gain();
    t_intl();
    t_hook();
    t_protect();
    t_freeze();
    t_reset();
    end_of_test();
  end
endmodule
